/* File: lds_params.svh */
`ifndef LDS_PARAMS_SVH
`define LDS_PARAMS_SVH
// Overview of operation
// - bus dominant past the timeout latches clamp flag; clears on recovery plus read
// - transceiver-mode bit reads 1 in transmit/receive mode, else 0
// - mode bit drops on an SPI mode change or a dominant transmit pin fault
// - LIN flag-read commands leave the transceiver-mode bit untouched
// - wake-receiver bit shows wake detection enabled; disabled blocks wake events
// - wake-receiver bit set by sleep with wake, reset by sleep without wake
// - wake-source flag sets on a wake event, clears on a flag read of its own channel
// - termination short flag latches; clears on recovery plus read
// - overtemperature flag latches; clears when below threshold plus read
// - receive pin low flag latches; clears on recovery plus read
// - receive pin recessive flag latches; clears on recovery plus read
// - transmit pin dominant flag latches; clears on recovery plus read
// - every SPI frame returns the fixed status byte first
// - write command type returns fixed status then extended status
// - both read command types return only the fixed status byte
`define LDS_CMD_RD_LIN1 16'h2780
`define LDS_CMD_RD_LIN2 16'h2980
`define LDS_WR_LIN1     8'h4c
`define LDS_WR_LIN2     8'h4e
`define LDS_CT_WRITE    2'h1
`define LDS_MD_POS      6
`define LDS_F_CLAMP     0
`define LDS_F_TXRX      1
`define LDS_F_WU        2
`define LDS_F_WAKE      3
`define LDS_F_TERM      4
`define LDS_F_OTEMP     5
`define LDS_F_RXLOW     6
`define LDS_F_RXREC     7
`define LDS_F_TXDOM     8
`define LDS_NFLAG       9
`define LDS_DOM_CYC     256
`define LDS_FRAME_BITS  16
`define LDS_BYTE_BITS   8
`endif

/* File: lds_pkg.sv */
package lds_pkg;
   // channel operating mode, one-hot
   typedef enum logic [3:0] {
      LDS_SLEEP_NOWU = 4'h1,
      LDS_SLEEP_WU   = 4'h2,
      LDS_STANDBY    = 4'h4,
      LDS_TXRX       = 4'h8
   } lds_mode_t;
   typedef logic [1:0] lds_mdcode_t;
endpackage

/* File: lds_lin_flags.sv */
`include "lds_params.svh"
module lds_lin_flags
   import lds_pkg::*;
#(
   parameter int NCH     = 2,
   parameter int DOM_CYC = `LDS_DOM_CYC
)(
   input  wire logic                      sys_clk,
   input  wire logic                      arst_n,
   input  wire logic                      spi_sclk,
   input  wire logic                      spi_cs_n,
   input  wire logic                      spi_mosi,
   output logic                           spi_miso,
   output logic                           spi_miso_oe,
   input  wire logic [NCH-1:0]            bus_dominant,
   input  wire logic [NCH-1:0]            term_short,
   input  wire logic [NCH-1:0]            over_temp,
   input  wire logic [NCH-1:0]            rxd_low,
   input  wire logic [NCH-1:0]            rxd_recessive,
   input  wire logic [NCH-1:0]            txd_dominant,
   input  wire logic [NCH-1:0]            wake_detect,
   output logic [NCH*`LDS_NFLAG-1:0]      lin_flags,
   output logic [NCH-1:0]                 txrx_mode,
   output logic [NCH-1:0]                 wake_receiver_bit
);

   localparam int NIN = 7 * NCH;

   function automatic logic latch_next(
      input logic flag,
      input logic cond,
      input logic rd
   );
      // a new or persisting fault outweighs the read
      latch_next = cond | (flag & ~rd);
   endfunction

   // ----------------------------------------------------------
   // link side, clocked by the SPI clock
   // ----------------------------------------------------------
   logic        link_rst_n;
   logic [15:0] rx_sh;
   logic [15:0] next_rx_sh;
   logic [4:0]  rx_cnt;
   logic [4:0]  next_rx_cnt;
   logic [15:0] cmd_word;
   logic [15:0] next_cmd_word;
   logic        done_tgl;
   logic        next_done_tgl;
   logic [15:0] tx_sh;
   logic [15:0] next_tx_sh;
   logic [4:0]  tx_cnt;
   logic [4:0]  next_tx_cnt;
   logic        next_oe;
   logic [15:0] status_hold;

   // chip select ends every frame; the command word and the toggle survive it
   assign link_rst_n = arst_n & ~spi_cs_n;

   always_comb
   begin
      next_rx_sh    = {rx_sh[14:0], spi_mosi};
      next_rx_cnt   = rx_cnt;
      next_cmd_word = cmd_word;
      next_done_tgl = done_tgl;
      if (rx_cnt < 5'(`LDS_FRAME_BITS))
      begin
         next_rx_cnt = rx_cnt + 5'h01;
      end
      if (rx_cnt == 5'(`LDS_FRAME_BITS - 1))
      begin
         next_cmd_word = next_rx_sh;
         next_done_tgl = ~done_tgl;
      end
   end

   always_ff @(negedge spi_sclk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         rx_sh  <= 16'h0000;
         rx_cnt <= 5'h00;
      end
      else
      begin
         rx_sh  <= next_rx_sh;
         rx_cnt <= next_rx_cnt;
      end
   end

   always_ff @(negedge spi_sclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cmd_word <= 16'h0000;
         done_tgl <= 1'b0;
      end
      else
      begin
         cmd_word <= next_cmd_word;
         done_tgl <= next_done_tgl;
      end
   end

   // status_hold is frozen while the frame runs, so it is quasi-static here
   always_comb
   begin
      next_tx_cnt = tx_cnt;
      next_tx_sh  = {tx_sh[14:0], 1'b0};
      next_oe     = spi_miso_oe;
      if (tx_cnt == 5'h00)
      begin
         next_tx_sh = status_hold;
         next_oe    = 1'b1;
      end
      if (tx_cnt < 5'(`LDS_FRAME_BITS))
      begin
         next_tx_cnt = tx_cnt + 5'h01;
      end
      // bits 15 and 14 sit at rx_sh[7:6] by the ninth rising edge
      if (tx_cnt == 5'(`LDS_BYTE_BITS) && rx_sh[7:6] != `LDS_CT_WRITE)
      begin
         next_oe = 1'b0;
      end
      if (tx_cnt == 5'(`LDS_FRAME_BITS))
      begin
         next_oe = 1'b0;
      end
   end

   always_ff @(posedge spi_sclk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         tx_sh       <= 16'h0000;
         tx_cnt      <= 5'h00;
         spi_miso_oe <= 1'b0;
      end
      else
      begin
         tx_sh       <= next_tx_sh;
         tx_cnt      <= next_tx_cnt;
         spi_miso_oe <= next_oe;
      end
   end

   assign spi_miso = tx_sh[15];

   // ----------------------------------------------------------
   // crossings into the system clock
   // ----------------------------------------------------------
   logic [NIN-1:0] in_s1;
   logic [NIN-1:0] in_s2;
   logic [2:0]     cs_s;
   logic [2:0]     tg_s;
   logic [NCH-1:0] wake_d;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         in_s1  <= '0;
         in_s2  <= '0;
         cs_s   <= 3'h7;
         tg_s   <= 3'h0;
         wake_d <= '0;
      end
      else
      begin
         in_s1  <= {wake_detect, txd_dominant, rxd_recessive, rxd_low,
                    over_temp, term_short, bus_dominant};
         in_s2  <= in_s1;
         cs_s   <= {cs_s[1:0], spi_cs_n};
         tg_s   <= {tg_s[1:0], done_tgl};
         wake_d <= in_s2[6*NCH +: NCH];
      end
   end

   logic           cmd_evt;
   logic [NCH-1:0] dom_s;
   logic [NCH-1:0] term_s;
   logic [NCH-1:0] ot_s;
   logic [NCH-1:0] rxl_s;
   logic [NCH-1:0] rxr_s;
   logic [NCH-1:0] txd_s;
   logic [NCH-1:0] wake_s;

   assign cmd_evt = tg_s[2] ^ tg_s[1];
   assign dom_s   = in_s2[0 +: NCH];
   assign term_s  = in_s2[NCH +: NCH];
   assign ot_s    = in_s2[2*NCH +: NCH];
   assign rxl_s   = in_s2[3*NCH +: NCH];
   assign rxr_s   = in_s2[4*NCH +: NCH];
   assign txd_s   = in_s2[5*NCH +: NCH];
   assign wake_s  = in_s2[6*NCH +: NCH];

   // ----------------------------------------------------------
   // per channel flags and mode
   // ----------------------------------------------------------
   lds_mode_t                   mode [NCH];
   lds_mode_t                   next_mode [NCH];
   logic [15:0]                 dom_cnt [NCH];
   logic [15:0]                 next_dom_cnt [NCH];
   logic [NCH*`LDS_NFLAG-1:0]   next_flags;
   logic [NCH-1:0]              rd_ch;
   logic [NCH-1:0]              wr_ch;
   logic [15:0]                 next_hold;
   logic                        any_fault;
   logic                        any_wake;
   logic [1:0]                  ch_any;

   always_comb
   begin
      lds_mdcode_t md;
      logic        clamp;
      logic        wu;
      int          b;
      md         = cmd_word[`LDS_MD_POS +: 2];
      next_flags = lin_flags;
      any_fault  = 1'b0;
      any_wake   = 1'b0;
      ch_any     = 2'b00;
      clamp      = 1'b0;
      wu         = 1'b0;
      b          = 0;
      rd_ch      = '0;
      wr_ch      = '0;
      rd_ch[0]   = cmd_evt && cmd_word == `LDS_CMD_RD_LIN1;
      wr_ch[0]   = cmd_evt && cmd_word[15:8] == `LDS_WR_LIN1;
      if (NCH > 1)
      begin
         rd_ch[NCH-1] = cmd_evt && cmd_word == `LDS_CMD_RD_LIN2;
         wr_ch[NCH-1] = cmd_evt && cmd_word[15:8] == `LDS_WR_LIN2;
      end
      for (int c = 0; c < NCH; c++)
      begin
         b               = c * `LDS_NFLAG;
         next_mode[c]    = mode[c];
         next_dom_cnt[c] = dom_s[c] ? dom_cnt[c] : 16'h0000;
         if (dom_s[c] && dom_cnt[c] < 16'(DOM_CYC))
         begin
            next_dom_cnt[c] = dom_cnt[c] + 16'h0001;
         end
         clamp = dom_s[c] && dom_cnt[c] >= 16'(DOM_CYC);
         if (wr_ch[c])
         begin
            case (md)
               2'h0:    next_mode[c] = LDS_SLEEP_NOWU;
               2'h1:    next_mode[c] = LDS_SLEEP_WU;
               2'h3:    next_mode[c] = LDS_TXRX;
               default: next_mode[c] = LDS_STANDBY;
            endcase
         end
         if (txd_s[c] && next_mode[c] == LDS_TXRX)
         begin
            next_mode[c] = LDS_STANDBY;
         end
         // wake detection tracks the last sleep entry
         wu = lin_flags[b + `LDS_F_WU];
         if (next_mode[c] == LDS_SLEEP_WU)
         begin
            wu = 1'b1;
         end
         else if (next_mode[c] == LDS_SLEEP_NOWU)
         begin
            wu = 1'b0;
         end
         next_flags[b + `LDS_F_WU]   = wu;
         next_flags[b + `LDS_F_TXRX] = next_mode[c] == LDS_TXRX;
         next_flags[b + `LDS_F_CLAMP] =
            latch_next(lin_flags[b + `LDS_F_CLAMP], clamp, rd_ch[c]);
         next_flags[b + `LDS_F_WAKE] = latch_next(lin_flags[b + `LDS_F_WAKE],
            wake_s[c] & ~wake_d[c] & lin_flags[b + `LDS_F_WU], rd_ch[c]);
         next_flags[b + `LDS_F_TERM] =
            latch_next(lin_flags[b + `LDS_F_TERM], term_s[c], rd_ch[c]);
         next_flags[b + `LDS_F_OTEMP] =
            latch_next(lin_flags[b + `LDS_F_OTEMP], ot_s[c], rd_ch[c]);
         next_flags[b + `LDS_F_RXLOW] =
            latch_next(lin_flags[b + `LDS_F_RXLOW], rxl_s[c], rd_ch[c]);
         next_flags[b + `LDS_F_RXREC] =
            latch_next(lin_flags[b + `LDS_F_RXREC], rxr_s[c], rd_ch[c]);
         next_flags[b + `LDS_F_TXDOM] =
            latch_next(lin_flags[b + `LDS_F_TXDOM], txd_s[c], rd_ch[c]);
         any_wake  = any_wake | lin_flags[b + `LDS_F_WAKE];
         any_fault = any_fault | lin_flags[b + `LDS_F_CLAMP] | (|lin_flags[b+4 +: 5]);
         if (c < 2)
         begin
            ch_any[c] = lin_flags[b + `LDS_F_WAKE] | lin_flags[b + `LDS_F_CLAMP]
                        | (|lin_flags[b+4 +: 5]);
         end
      end
      // fixed byte: pending, wake, LIN group; extended byte: per channel source
      next_hold = status_hold;
      if (cs_s[1])
      begin
         next_hold = {any_fault, any_wake, 1'b0, 1'b0, |ch_any, 3'h0,
                      2'h0, ch_any[1], ch_any[0], 4'h0};
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lin_flags   <= '0;
         status_hold <= 16'h0000;
         for (int c = 0; c < NCH; c++)
         begin
            mode[c]    <= LDS_STANDBY;
            dom_cnt[c] <= 16'h0000;
         end
      end
      else
      begin
         lin_flags   <= next_flags;
         status_hold <= next_hold;
         for (int c = 0; c < NCH; c++)
         begin
            mode[c]    <= next_mode[c];
            dom_cnt[c] <= next_dom_cnt[c];
         end
      end
   end

   always_comb
   begin
      for (int c = 0; c < NCH; c++)
      begin
         txrx_mode[c]         = lin_flags[c*`LDS_NFLAG + `LDS_F_TXRX];
         wake_receiver_bit[c] = lin_flags[c*`LDS_NFLAG + `LDS_F_WU];
      end
   end

   // ----------------------------------------------------------
   // checks on channel 0 and on the read frame length
   // ----------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   a_clamp_sets: assert property (
      dom_s[0] && dom_cnt[0] >= 16'(DOM_CYC) |=> lin_flags[`LDS_F_CLAMP])
      else $error("clamp flag not set after timeout");
   a_txrx_follows: assert property (
      ##1 txrx_mode[0] == ($past(next_mode[0]) == LDS_TXRX))
      else $error("mode bit disagrees with channel mode");
   a_txd_forces: assert property (
      txd_s[0] |=> !txrx_mode[0])
      else $error("dominant transmit pin left mode bit set");
   a_read_keeps_mode: assert property (
      rd_ch[0] && !txd_s[0] |=> $stable(txrx_mode[0]) && $stable(wake_receiver_bit[0]))
      else $error("flag read changed a real-time bit");
   a_wake_gated: assert property (
      !wake_receiver_bit[0] && !lin_flags[`LDS_F_WAKE] |=> !lin_flags[`LDS_F_WAKE])
      else $error("wake flagged while wake detection disabled");
   a_wake_read: assert property (
      rd_ch[0] && !(wake_s[0] && !wake_d[0]) |=> !lin_flags[`LDS_F_WAKE])
      else $error("wake flag survived a read");
   a_fault_persists: assert property (
      rd_ch[0] && (term_s[0] || ot_s[0]) |=> (lin_flags[`LDS_F_TERM] || !$past(term_s[0]))
         && (lin_flags[`LDS_F_OTEMP] || !$past(ot_s[0])))
      else $error("fault flag cleared while fault present");
   a_flag_recovers: assert property (
      rd_ch[0] && !rxl_s[0] && !rxr_s[0] |=> !lin_flags[`LDS_F_RXLOW] && !lin_flags[`LDS_F_RXREC])
      else $error("receive fault flag not cleared by read");
   a_read_one_byte: assert property (
      @(posedge spi_sclk) disable iff (!link_rst_n)
      tx_cnt == 5'h08 && rx_sh[7:6] != `LDS_CT_WRITE |=> !spi_miso_oe)
      else $error("read frame drove past the fixed byte");

endmodule // lds_lin_flags

/* File: lds_spi_host.sv */
module lds_spi_host (
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_mosi,
   input  wire logic spi_miso,
   input  wire logic spi_miso_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   // ----------------------------------------
   // one 16-bit frame, 32 ns sclk, idle low
   // ----------------------------------------
   // sclk only runs inside frames; the 64 ns lead lets the status snapshot freeze
   task automatic xfer(input logic [15:0] w, output logic [15:0] r, output int noe);
      r = 16'h0000;
      noe = 0;
      #3;
      spi_cs_n = 1'b0;
      #64;
      for (int i = 15; i >= 0; i--)
      begin
         spi_sclk = 1'b1;
         spi_mosi = w[i];
         #16;
         spi_sclk = 1'b0;
         r[i] = spi_miso_oe ? spi_miso : 1'b0;
         if (spi_miso_oe === 1'b1)
            noe++;
         #16;
      end
      #16;
      spi_cs_n = 1'b1;
      // released data line must not keep showing the last bit
      spi_mosi = ~spi_mosi;
      #100;
   endtask
endmodule // lds_spi_host

/* File: tb_lin_diag_status_flags.sv */
`include "lds_params.svh"
module tb_lin_diag_status_flags;
   import lds_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int NCH  = 2;
   localparam int DOMC = 8;
   logic              sys_clk;
   logic              arst_n;
   logic              spi_sclk;
   logic              spi_cs_n;
   logic              spi_mosi;
   logic              spi_miso;
   logic              spi_miso_oe;
   logic [NCH-1:0]    bus_dominant;
   logic [NCH-1:0]    term_short;
   logic [NCH-1:0]    over_temp;
   logic [NCH-1:0]    rxd_low;
   logic [NCH-1:0]    rxd_recessive;
   logic [NCH-1:0]    txd_dominant;
   logic [NCH-1:0]    wake_detect;
   logic [NCH*9-1:0]  lin_flags;
   logic [NCH-1:0]    txrx_mode;
   logic [NCH-1:0]    wake_receiver_bit;
   logic [15:0]       resp;
   int                noe;
   int                fail_count;
   int                cmp_count;
   int                fb[6] = '{`LDS_F_CLAMP, `LDS_F_TERM, `LDS_F_OTEMP,
                                `LDS_F_RXLOW, `LDS_F_RXREC, `LDS_F_TXDOM};

   lds_lin_flags #(.NCH(NCH), .DOM_CYC(DOMC)) i_lds_lin_flags (
      .sys_clk(sys_clk), .arst_n(arst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .bus_dominant(bus_dominant), .term_short(term_short), .over_temp(over_temp),
      .rxd_low(rxd_low), .rxd_recessive(rxd_recessive), .txd_dominant(txd_dominant),
      .wake_detect(wake_detect), .lin_flags(lin_flags), .txrx_mode(txrx_mode),
      .wake_receiver_bit(wake_receiver_bit));

   lds_spi_host i_lds_spi_host (
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

   initial
   begin
      sys_clk = 1'b0;
   end
   always #10 sys_clk = ~sys_clk;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // sys side needs a few cycles after cs_n rises to apply the command
   task automatic cmd(input logic [15:0] w);
      i_lds_spi_host.xfer(w, resp, noe);
      wt(8);
   endtask

   function automatic logic flag(input int c, input int f);
      return lin_flags[c*`LDS_NFLAG+f];
   endfunction

   task automatic set_fault(input int k, input int c, input logic v);
      case (k)
         0: bus_dominant[c] = v;
         1: term_short[c] = v;
         2: over_temp[c] = v;
         3: rxd_low[c] = v;
         4: rxd_recessive[c] = v;
         default: txd_dominant[c] = v;
      endcase
   endtask

   task automatic give_verdict();
      $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_frames();
      check(32'(lin_flags), 32'h0);
      check(32'(spi_miso_oe), 32'h0);
      i_lds_spi_host.xfer(`LDS_CMD_RD_LIN1, resp, noe);
      check(32'(resp[15:8]), 32'h0);
      check(32'(noe), 32'h8);
      i_lds_spi_host.xfer(16'hc000, resp, noe);
      check(32'(noe), 32'h8);
      i_lds_spi_host.xfer({`LDS_WR_LIN1, 8'h80}, resp, noe);
      check(32'(resp), 32'h0);
      check(32'(noe), 32'h10);
      check(32'(spi_miso_oe), 32'h0);
      wt(8);
   endtask

   task automatic t_mode();
      cmd({`LDS_WR_LIN1, 8'hc0});
      check(32'(txrx_mode), 32'h1);
      check(32'(flag(0, `LDS_F_TXRX)), 32'h1);
      cmd(`LDS_CMD_RD_LIN1);
      check(32'(txrx_mode), 32'h1);
      cmd({`LDS_WR_LIN1, 8'h80});
      check(32'(txrx_mode), 32'h0);
      cmd({`LDS_WR_LIN1, 8'hc0});
      check(32'(txrx_mode), 32'h1);
      cmd({`LDS_WR_LIN1, 8'h40});
      check(32'(txrx_mode), 32'h0);
      check(32'(wake_receiver_bit), 32'h1);
      cmd(`LDS_CMD_RD_LIN1);
      check(32'(wake_receiver_bit), 32'h1);
      cmd({`LDS_WR_LIN1, 8'h00});
      check(32'(wake_receiver_bit), 32'h0);
   endtask

   task automatic t_wake();
      wake_detect[1] = 1'b1;
      wt(6);
      check(32'(flag(1, `LDS_F_WAKE)), 32'h0);
      wake_detect[1] = 1'b0;
      cmd({`LDS_WR_LIN2, 8'h40});
      check(32'(wake_receiver_bit), 32'h2);
      wake_detect[1] = 1'b1;
      wt(6);
      check(32'(flag(1, `LDS_F_WAKE)), 32'h1);
      check(32'(flag(0, `LDS_F_WAKE)), 32'h0);
      cmd({`LDS_WR_LIN2, 8'h40});
      check(32'(resp), 32'h4820);
      // detector still high, but no new edge: read must clear anyway
      cmd(`LDS_CMD_RD_LIN2);
      check(32'(flag(1, `LDS_F_WAKE)), 32'h0);
      wake_detect[1] = 1'b0;
   endtask

   task automatic t_faults();
      bus_dominant[0] = 1'b1;
      wt(DOMC / 2);
      bus_dominant[0] = 1'b0;
      wt(6);
      check(32'(flag(0, `LDS_F_CLAMP)), 32'h0);
      cmd({`LDS_WR_LIN1, 8'hc0});
      for (int k = 0; k < 6; k++)
      begin
         set_fault(k, 0, 1'b1);
         wt(DOMC + 12);
         check(32'(flag(0, fb[k])), 32'h1);
         check(32'(flag(1, fb[k])), 32'h0);
         if (k == 5)
            check(32'(txrx_mode), 32'h0);
         cmd(`LDS_CMD_RD_LIN1);
         check(32'(resp[15:8]), 32'h88);
         check(32'(flag(0, fb[k])), 32'h1);
         set_fault(k, 0, 1'b0);
         wt(6);
         check(32'(flag(0, fb[k])), 32'h1);
         cmd(`LDS_CMD_RD_LIN1);
         check(32'(flag(0, fb[k])), 32'h0);
      end
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      fail_count = 0;
      cmp_count = 0;
      arst_n = 1'b0;
      {bus_dominant, term_short, over_temp, rxd_low} = '0;
      {rxd_recessive, txd_dominant, wake_detect} = '0;
      repeat (8) @(negedge sys_clk);
      arst_n = 1'b1;
      wt(6);
      t_frames();
      t_mode();
      t_wake();
      t_faults();
      give_verdict();
   end

   // 26 frames of under 1 us each; generous margin
   initial
   begin
      #300000;
      fail_count++;
      give_verdict();
   end
endmodule // tb_lin_diag_status_flags
